// file: logic/arss_defs.svh
// Purpose: Shared constants of the repeat sweep converter sequencer
// Assumes: One clock, converter clock equals sys_clk
// Notes:   Offsets, field positions and cycle counts
//
// What this block does
// - Sweep sixteen inputs, base group then second
// - Group field picks second group; 10b is 0
// - Software enables DMA mode before sweeping
// - Software trigger: start when flag written 1
// - Trigger select 00b: external pin falling edge
// - Trigger select 01b: thinned timer B2 request
// - Trigger select 10b: timer A0 request
// - Hardware triggers ignored while flag is 0
// - Trigger during conversion restarts sweep from start
// - Sweep repeats until software clears flag
// - DMA request after each input, none when a trigger restarts in its last cycle
// - DMA mode: all results to first register
// - Software never reads first result directly
// - Ten-bit result in 9:0, eight-bit in 7:0
// - Sample-hold conversion: 28 or 33 cycles
// - Software sets sample-hold before starting
// - DMA width 8 or 16 bits by resolution
// - Sampling lasts 2 cycles, 3 with hold
// - Control changes only while conversion stopped
`ifndef ARSS_DEFS_SVH
`define ARSS_DEFS_SVH

// ----------------------------------------------------------------
// Device control registers
// ----------------------------------------------------------------
`define ARSS_REG0          3'h0
`define ARSS_REG1          3'h1
`define ARSS_REG2          3'h2
`define ARSS_REG3          3'h3
`define ARSS_REG4          3'h4
`define ARSS_R0_START      0
`define ARSS_R0_TSS        1
`define ARSS_R1_RES10      0
`define ARSS_R2_SH         0
`define ARSS_R2_HW_LO      1
`define ARSS_R2_HW_HI      2
`define ARSS_R3_DMA        0
`define ARSS_R4_GRP_LO     0
`define ARSS_R4_GRP_HI     1
`define ARSS_CTL_RESET     8'h00

// ----------------------------------------------------------------
// Field encodings
// ----------------------------------------------------------------
`define ARSS_HW_EXT        2'h0
`define ARSS_HW_TB2        2'h1
`define ARSS_HW_TA0        2'h2
`define ARSS_GRP_G15       2'h0
`define ARSS_GRP_G2        2'h1
`define ARSS_GRP_G0        2'h2
`define ARSS_BASE_GRP      5'h10
`define ARSS_LAST_POS      4'hf

// ----------------------------------------------------------------
// Cycle counts in converter clocks
// ----------------------------------------------------------------
`define ARSS_SH_CYC_8      6'h1c
`define ARSS_SH_CYC_10     6'h21
`define ARSS_SAMP_SH       6'h03
`define ARSS_SAMP_NOSH     6'h02

// ----------------------------------------------------------------
// Controller APB map
// ----------------------------------------------------------------
`define ARSS_A_CTL0        8'h00
`define ARSS_A_CTL4        8'h10
`define ARSS_A_TRIG        8'h14
`define ARSS_A_RESULT      8'h18
`define ARSS_A_XFER        8'h1c
`define ARSS_A_STATUS      8'h20
`define ARSS_TRIG_RESET    1'b1

`endif

// file: logic/arss_pkg.sv
// Purpose: Types of the repeat sweep converter sequencer
// Assumes: Constants come from arss_defs.svh
// Notes:   Sequencer and controller each keep their whole state in one struct
package arss_pkg;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_ARMED   = 2'b01,
        ST_SAMPLE  = 2'b10,
        ST_CONVERT = 2'b11
    } arss_state_e;

    typedef struct packed {
        arss_state_e state;
        logic        start_flag;
        logic        tss;
        logic [1:0]  hw_sel;
        logic        res10;
        logic        sh;
        logic        dma_en;
        logic [1:0]  grp_sel;
        logic [5:0]  cnt;
        logic [3:0]  pos;
        logic [9:0]  hold;
        logic [15:0] result;
        logic        dma_req;
        logic        trig_prev;
        logic [7:0]  ain_sel;
        logic        busy;
    } arss_dev_s;

    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
        logic        ctl_wr;
        logic [2:0]  ctl_sel;
        logic [7:0]  ctl_wdata;
        logic [4:0][7:0] shadow;
        logic        ext_trig_n;
        logic        tb2_irq;
        logic        ta0_irq;
        logic [15:0] result;
        logic        result_new;
        logic [15:0] xfer_cnt;
    } arss_host_s;

endpackage : arss_pkg

// file: logic/arss_link_if.sv
// Purpose: Link between converter sequencer and its controller
// Assumes: Both ends run on the same sys_clk
// Notes:   Every signal driven from a flip-flop of its end
`timescale 1ns/1ns
interface arss_link_if;
    logic        ctl_wr;
    logic [2:0]  ctl_sel;
    logic [7:0]  ctl_wdata;
    logic        ext_trig_n;
    logic        tb2_irq;
    logic        ta0_irq;
    logic        dma_req;
    logic [15:0] result;
    logic        busy;
    logic        start_flag;

    modport dev (
        input  ctl_wr, ctl_sel, ctl_wdata, ext_trig_n, tb2_irq, ta0_irq,
        output dma_req, result, busy, start_flag
    );
    modport ctl (
        output ctl_wr, ctl_sel, ctl_wdata, ext_trig_n, tb2_irq, ta0_irq,
        input  dma_req, result, busy, start_flag
    );
endinterface : arss_link_if

// file: logic/arss_sequencer.sv
// Purpose: Repeat sixteen-input sweep sequencer of the converter
// Assumes: ain_code is the comparator code for the input on ain_sel
// Notes:   Conversion cycle counts without sample-hold are parameters
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ns
`include "arss_defs.svh"
module arss_sequencer #(
    parameter logic [5:0] CONV_NOSH_8  = 6'h28,
    parameter logic [5:0] CONV_NOSH_10 = 6'h31
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    arss_link_if.dev         lnk,
    input  wire logic [9:0]  ain_code,
    output      logic [7:0]  ain_sel,
    output      logic        busy
);

    arss_pkg::arss_dev_s s;
    arss_pkg::arss_dev_s next_s;
    logic                fall_edge;
    logic                hw_trig;
    logic [9:0]          code;

    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------
    function automatic logic [5:0] conv_cycles(input logic sh, input logic res10);
        if (sh)
            conv_cycles = res10 ? `ARSS_SH_CYC_10 : `ARSS_SH_CYC_8;
        else
            conv_cycles = res10 ? CONV_NOSH_10 : CONV_NOSH_8;
    endfunction : conv_cycles

    function automatic logic [5:0] samp_cycles(input logic sh);
        samp_cycles = sh ? `ARSS_SAMP_SH : `ARSS_SAMP_NOSH;
    endfunction : samp_cycles

    // Input number of the input, group in 7:3 and position in 2:0, base group shown as 16
    function automatic logic [7:0] chan_of(input logic [1:0] grp, input logic [3:0] pos);
        logic [4:0] g;
        g = 5'h00;
        if (!pos[3])
            g = `ARSS_BASE_GRP;
        else if (grp == `ARSS_GRP_G0)
            g = 5'h00;
        else if (grp == `ARSS_GRP_G2)
            g = 5'h02;
        else if (grp == `ARSS_GRP_G15)
            g = 5'h0f;
        chan_of = {g, pos[2:0]};
    endfunction : chan_of

    // ----------------------------------------------------------------
    // Trigger selection
    // ----------------------------------------------------------------
    always_comb begin
        fall_edge = s.trig_prev & ~lnk.ext_trig_n;
        hw_trig   = 1'b0;
        if (s.tss && s.start_flag) begin
            if (s.hw_sel == `ARSS_HW_EXT)
                hw_trig = fall_edge;
            else if (s.hw_sel == `ARSS_HW_TB2)
                hw_trig = lnk.tb2_irq;
            else if (s.hw_sel == `ARSS_HW_TA0)
                hw_trig = lnk.ta0_irq;
        end
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_s           = s;
        next_s.dma_req   = 1'b0;
        next_s.trig_prev = lnk.ext_trig_n;
        code             = s.sh ? s.hold : ain_code;

        if (lnk.ctl_wr) begin
            case (lnk.ctl_sel)
                `ARSS_REG0: begin
                    next_s.start_flag = lnk.ctl_wdata[`ARSS_R0_START];
                    next_s.tss        = lnk.ctl_wdata[`ARSS_R0_TSS];
                end
                `ARSS_REG1: next_s.res10 = lnk.ctl_wdata[`ARSS_R1_RES10];
                `ARSS_REG2: begin
                    next_s.sh     = lnk.ctl_wdata[`ARSS_R2_SH];
                    next_s.hw_sel = lnk.ctl_wdata[`ARSS_R2_HW_HI:`ARSS_R2_HW_LO];
                end
                `ARSS_REG3: next_s.dma_en = lnk.ctl_wdata[`ARSS_R3_DMA];
                `ARSS_REG4: begin
                    next_s.grp_sel = lnk.ctl_wdata[`ARSS_R4_GRP_HI:`ARSS_R4_GRP_LO];
                end
                default: ;
            endcase
        end

        case (s.state)
            arss_pkg::ST_IDLE: begin
                if (s.start_flag) begin
                    next_s.cnt = 6'h00;
                    next_s.pos = 4'h0;
                    if (s.tss)
                        next_s.state = arss_pkg::ST_ARMED;
                    else
                        next_s.state = arss_pkg::ST_SAMPLE;
                end
            end
            arss_pkg::ST_ARMED: begin
                if (hw_trig) begin
                    next_s.cnt   = 6'h00;
                    next_s.pos   = 4'h0;
                    next_s.state = arss_pkg::ST_SAMPLE;
                end
            end
            arss_pkg::ST_SAMPLE: begin
                next_s.cnt = s.cnt + 6'h01;
                if (s.cnt == samp_cycles(s.sh) - 6'h01) begin
                    next_s.hold  = ain_code;
                    next_s.state = arss_pkg::ST_CONVERT;
                end
            end
            arss_pkg::ST_CONVERT: begin
                next_s.cnt = s.cnt + 6'h01;
                if (s.cnt == conv_cycles(s.sh, s.res10) - 6'h01) begin
                    if (s.res10)
                        next_s.result = {6'h00, code};
                    else
                        next_s.result = {8'h00, code[9:2]};
                    next_s.dma_req = s.dma_en;
                    next_s.cnt     = 6'h00;
                    next_s.state   = arss_pkg::ST_SAMPLE;
                    if (s.pos == `ARSS_LAST_POS)
                        next_s.pos = 4'h0;
                    else
                        next_s.pos = s.pos + 4'h1;
                end
            end
            default: next_s.state = arss_pkg::ST_IDLE;
        endcase

        if (s.busy && hw_trig) begin
            next_s.cnt     = 6'h00;
            next_s.pos     = 4'h0;
            next_s.dma_req = 1'b0;
            next_s.state   = arss_pkg::ST_SAMPLE;
        end

        if (!next_s.start_flag) begin
            next_s.state   = arss_pkg::ST_IDLE;
            next_s.cnt     = 6'h00;
            next_s.pos     = 4'h0;
        end

        next_s.busy    = (next_s.state == arss_pkg::ST_SAMPLE) ||
                         (next_s.state == arss_pkg::ST_CONVERT);
        next_s.ain_sel = chan_of(next_s.grp_sel, next_s.pos);
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s           <= '0;
            s.state     <= arss_pkg::ST_IDLE;
            s.trig_prev <= 1'b1;
            s.ain_sel   <= {`ARSS_BASE_GRP, 3'h0};
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign lnk.dma_req    = s.dma_req;
    assign lnk.result     = s.result;
    assign lnk.busy       = s.busy;
    assign lnk.start_flag = s.start_flag;
    assign ain_sel        = s.ain_sel;
    assign busy           = s.busy;

endmodule : arss_sequencer

// file: logic/arss_controller.sv
// Purpose: APB controller and DMA sink facing the sequencer
// Assumes: APB3 slave, zero wait states, 32-bit data
// Notes:   Control words forwarded one link write per APB write
`timescale 1ns/1ns
`include "arss_defs.svh"
module arss_controller (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output      logic        pready,
    output      logic [31:0] prdata,
    output      logic        pslverr,
    arss_link_if.ctl         lnk
);

    arss_pkg::arss_host_s h;
    arss_pkg::arss_host_s next_h;
    logic                 setup;
    logic                 access;
    logic                 mapped;
    logic [31:0]          rdata;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    always_comb begin
        mapped = 1'b1;
        rdata  = 32'h00000000;
        if (paddr <= `ARSS_A_CTL4 && paddr[1:0] == 2'h0)
            rdata = {24'h000000, h.shadow[paddr[4:2]]};
        else if (paddr == `ARSS_A_TRIG)
            rdata = {31'h00000000, h.ext_trig_n};
        else if (paddr == `ARSS_A_RESULT)
            rdata = {15'h0000, h.result_new, h.result};
        else if (paddr == `ARSS_A_XFER)
            rdata = {16'h0000, h.xfer_cnt};
        else if (paddr == `ARSS_A_STATUS)
            rdata = {30'h00000000, lnk.start_flag, lnk.busy};
        else
            mapped = 1'b0;
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        setup          = psel & ~penable;
        access         = psel & penable & h.pready;
        next_h         = h;
        next_h.pready  = setup;
        next_h.ctl_wr  = 1'b0;
        next_h.tb2_irq = 1'b0;
        next_h.ta0_irq = 1'b0;
        if (setup) begin
            next_h.prdata  = pwrite ? 32'h00000000 : rdata;
            next_h.pslverr = ~mapped;
        end

        if (access && !pwrite && paddr == `ARSS_A_RESULT)
            next_h.result_new = 1'b0;

        if (access && pwrite && mapped) begin
            if (paddr <= `ARSS_A_CTL4) begin
                next_h.ctl_wr    = 1'b1;
                next_h.ctl_sel   = paddr[4:2];
                next_h.ctl_wdata = pwdata[7:0];
                next_h.shadow[paddr[4:2]] = pwdata[7:0];
            end else if (paddr == `ARSS_A_TRIG) begin
                next_h.ext_trig_n = pwdata[0];
                next_h.tb2_irq    = pwdata[1];
                next_h.ta0_irq    = pwdata[2];
            end
        end

        // DMA sink; capture wins over the read clear
        if (lnk.dma_req) begin
            if (h.shadow[`ARSS_REG1][`ARSS_R1_RES10])
                next_h.result = lnk.result;
            else
                next_h.result = {8'h00, lnk.result[7:0]};
            next_h.result_new = 1'b1;
            next_h.xfer_cnt   = h.xfer_cnt + 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            h            <= '0;
            h.shadow     <= {5{`ARSS_CTL_RESET}};
            h.ext_trig_n <= `ARSS_TRIG_RESET;
        end else begin
            h <= next_h;
        end
    end

    assign pready         = h.pready;
    assign prdata         = h.prdata;
    assign pslverr        = h.pslverr;
    assign lnk.ctl_wr     = h.ctl_wr;
    assign lnk.ctl_sel    = h.ctl_sel;
    assign lnk.ctl_wdata  = h.ctl_wdata;
    assign lnk.ext_trig_n = h.ext_trig_n;
    assign lnk.tb2_irq    = h.tb2_irq;
    assign lnk.ta0_irq    = h.ta0_irq;

endmodule : arss_controller

// file: verification/arss_link_props.sv
// Purpose: Link checker of the repeat sweep converter sequencer
// Assumes: Control shadows follow the link writes
// Notes:   Instantiated beside the link in the bench top
`timescale 1ns/1ns
`include "arss_defs.svh"
module arss_link_props #(
    parameter logic [5:0] CONV_NOSH_8  = 6'h28,
    parameter logic [5:0] CONV_NOSH_10 = 6'h31
) (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        ctl_wr,
    input wire logic [2:0]  ctl_sel,
    input wire logic [7:0]  ctl_wdata,
    input wire logic        ext_trig_n,
    input wire logic        tb2_irq,
    input wire logic        ta0_irq,
    input wire logic        dma_req,
    input wire logic [15:0] result,
    input wire logic        busy,
    input wire logic        start_flag
);
    // ------------------------------------------------------------
    // Shadows, trigger decode, conversion counter
    // ------------------------------------------------------------
    logic       tss, res10, sh, dma_en, ext_prev, restarted, trig_any, trig_sel;
    logic [1:0] hw;
    logic [5:0] cnt, conv_len;

    assign conv_len = sh ? (res10 ? `ARSS_SH_CYC_10 : `ARSS_SH_CYC_8)
                         : (res10 ? CONV_NOSH_10 : CONV_NOSH_8);
    assign trig_any = tb2_irq | ta0_irq | (ext_prev & ~ext_trig_n);
    assign trig_sel = tss & ((hw == `ARSS_HW_EXT) ? (ext_prev & ~ext_trig_n) :
                             (hw == `ARSS_HW_TB2) ? tb2_irq :
                             (hw == `ARSS_HW_TA0) ? ta0_irq : 1'b0);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            {tss, res10, sh, dma_en, restarted} <= 5'h00;
            hw       <= 2'h0;
            ext_prev <= 1'b1;
            cnt      <= 6'h00;
        end else begin
            ext_prev  <= ext_trig_n;
            cnt       <= !busy ? 6'h00 : dma_req ? 6'h01 : cnt + 6'h01;
            restarted <= (trig_sel && busy) ? 1'b1 : dma_req ? 1'b0 : restarted;
            if (ctl_wr) begin
                case (ctl_sel)
                    3'h0: tss <= ctl_wdata[1];
                    3'h1: res10 <= ctl_wdata[0];
                    3'h2: {hw, sh} <= ctl_wdata[2:0];
                    3'h3: dma_en <= ctl_wdata[0];
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_conv_length: assert property (dma_req && !restarted |-> cnt == conv_len)
        else $error("conversion length wrong");
    a_dma_gated: assert property (dma_req |-> dma_en)
        else $error("dma request without dma mode");
    a_idle_quiet: assert property (!start_flag && $past(start_flag) == 1'b0 |-> !dma_req)
        else $error("dma request while stopped");
    a_result_moves: assert property ($changed(result) |-> dma_req)
        else $error("result changed without dma request");
    a_res_width: assert property (dma_req |-> (res10 ? result[15:10] == 6'h00
                                                     : result[15:8] == 8'h00))
        else $error("result wider than resolution");
    a_soft_start: assert property (ctl_wr && ctl_sel == 3'h0 && ctl_wdata[1:0] == 2'b01
                                   && !busy |-> ##2 busy)
        else $error("software start missing");
    a_flag_follow: assert property (ctl_wr && ctl_sel == 3'h0
                                    |=> start_flag == $past(ctl_wdata[0]))
        else $error("start flag not written");
    a_clear_stops: assert property (ctl_wr && ctl_sel == 3'h0 && !ctl_wdata[0]
                                    |-> ##2 !busy)
        else $error("clear did not stop");
    a_trig_ignored: assert property (trig_any && !start_flag |-> ##2 !busy)
        else $error("trigger acted while flag clear");
    a_hw_start: assert property (trig_sel && start_flag && !busy |-> ##[1:2] busy)
        else $error("hardware trigger did not start");

    cover property (dma_req && res10);
    cover property (trig_sel && busy);
    cover property ($fell(busy));
endmodule : arss_link_props

// file: verification/test_adc_repeat_sweep_sequencer.sv
// Purpose: Self-checking bench of both sequencer ends over the link
// Assumes: Zero-wait APB controller, results through the DMA path
// Notes:   Model predicts every result from a random code table
`timescale 1ns/1ns
`include "arss_defs.svh"
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin error_cnt++; \
    $display("[ERR] %s exp=%0h got=%0h", n, e, s); end end
module test_adc_repeat_sweep_sequencer;
    logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr, seq_busy, err;
    logic [7:0]  paddr, ain_sel, sel;
    logic [31:0] pwdata, prdata, rd, seed;
    logic [9:0]  ain_code;
    logic [9:0]  tbl [256];
    logic        tss, res10, sf, ext_prev, trig;
    logic [1:0]  hw, grp;
    logic [15:0] last_exp;
    int          error_cnt, checked, ndma, pos, n;

    arss_link_if lnk ();
    arss_sequencer u_arss_sequencer (.sys_clk(sys_clk), .rst(rst), .lnk(lnk.dev),
        .ain_code(ain_code), .ain_sel(ain_sel), .busy(seq_busy));
    arss_controller u_arss_controller (.sys_clk(sys_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .lnk(lnk.ctl));
    arss_link_props u_arss_link_props (.sys_clk(sys_clk), .rst(rst),
        .ctl_wr(lnk.ctl_wr), .ctl_sel(lnk.ctl_sel), .ctl_wdata(lnk.ctl_wdata),
        .ext_trig_n(lnk.ext_trig_n), .tb2_irq(lnk.tb2_irq), .ta0_irq(lnk.ta0_irq),
        .dma_req(lnk.dma_req), .result(lnk.result), .busy(lnk.busy),
        .start_flag(lnk.start_flag));

    // ------------------------------------------------------------
    // Clock, analog source, reference model
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) ain_code <= tbl[ain_sel];

    always @(posedge sys_clk) begin
        if (!rst) begin
            trig = tss && sf && ((hw == 2'h0) ? (ext_prev && !lnk.ext_trig_n) :
                                 (hw == 2'h1) ? lnk.tb2_irq : (hw == 2'h2) && lnk.ta0_irq);
            if (lnk.dma_req) begin
                sel = (pos < 8) ? {5'h10, pos[2:0]} : {((grp == 2'h2) ? 5'h00 :
                      (grp == 2'h1) ? 5'h02 : 5'h0f), pos[2:0]};
                last_exp = res10 ? {6'h00, tbl[sel]} : {8'h00, tbl[sel][9:2]};
                `CHK("result", last_exp, lnk.result)
                pos = (pos + 1) % 16;
                ndma++;
            end
            if (trig) begin
                pos = 0;
            end
        end
        ext_prev = lnk.ext_trig_n;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic ctl0(input logic s, input logic t);
        if (s) pos = 0;
        sf = s;
        tss = t;
        apb(1'b1, 8'h00, {30'h0, t, s});
    endtask : ctl0

    task automatic fire();
        if (hw == 2'h0) begin
            apb(1'b1, 8'h14, 32'h0);
            apb(1'b1, 8'h14, 32'h1);
        end else apb(1'b1, 8'h14, (hw == 2'h1) ? 32'h3 : 32'h5);
    endtask : fire

    task automatic wait_dma(input int cnt);
        int t;
        int goal;
        goal = ndma + cnt;
        t = 0;
        while (ndma < goal && t < 4000) begin
            @(posedge sys_clk);
            t++;
        end
        `CHK("dma_count", 1'b1, ndma >= goal)
    endtask : wait_dma

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        #(40000 * 50);
        error_cnt++;
        conclude();
    end

    initial begin
        {rst, psel, penable, pwrite, tss, res10, sf} = 7'h40;
        {paddr, pwdata, hw, grp} = '0;
        {error_cnt, checked, ndma, pos} = '0;
        seed = 32'd78306;
        for (int i = 0; i < 256; i++) begin
            seed = xs(seed);
            tbl[i] = seed[9:0];
        end
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        apb(1'b1, 8'h0c, 32'h1);
        for (int k = 0; k < 4; k++) begin
            res10 = k[0];
            grp = (k == 1) ? 2'h1 : (k == 2) ? 2'h0 : 2'h2;
            apb(1'b1, 8'h04, {31'h0, res10});
            apb(1'b1, 8'h08, {31'h0, k != 3});
            apb(1'b1, 8'h10, {30'h0, grp});
            ctl0(1'b1, 1'b0);
            wait_dma(18);
            apb(1'b0, 8'h20, 32'h0);
            `CHK("status_run", 32'h3, rd)
            ctl0(1'b0, 1'b0);
            repeat (5) @(posedge sys_clk);
            n = ndma;
            repeat (120) @(posedge sys_clk);
            `CHK("busy_stop", 1'b0, seq_busy)
            `CHK("dma_after_stop", n, ndma)
        end
        for (int h = 0; h < 3; h++) begin
            hw = h[1:0];
            apb(1'b1, 8'h08, {29'h0, hw, 1'b1});
            ctl0(1'b0, 1'b1);
            fire();
            repeat (10) @(posedge sys_clk);
            `CHK("busy_flag_clear", 1'b0, seq_busy)
            ctl0(1'b1, 1'b1);
            repeat (10) @(posedge sys_clk);
            `CHK("busy_no_trigger", 1'b0, seq_busy)
            fire();
            wait_dma(3);
            repeat (5) @(posedge sys_clk);
            fire();
            wait_dma(17);
            ctl0(1'b0, 1'b1);
            repeat (60) @(posedge sys_clk);
        end
        apb(1'b0, 8'h18, 32'h0);
        `CHK("result_reg", last_exp, rd[15:0])
        `CHK("result_new", 1'b1, rd[16])
        apb(1'b0, 8'h1c, 32'h0);
        `CHK("xfer_cnt", ndma, rd)
        apb(1'b0, 8'h40, 32'h0);
        `CHK("unmapped_err", 1'b1, err)
        `CHK("unmapped_data", 32'h0, rd)
        conclude();
    end
endmodule : test_adc_repeat_sweep_sequencer
